/* verilog/io_input_debounce_events.v */
// Camera I/O port block: pin control, per-line debounce, edge event flags,
// interrupt status, all reached over an APB slave.
// Assumes pins arrive asynchronously and the enumeration flag is a level.
`timescale 1ns/1ps
`include "io_defines.vh"

module io_input_debounce_events #(
  parameter NLINES = 3,
  parameter DW = `DEB_W,
  parameter TICK_CYCLES = `TICK_CYCLES
) (
  // Clock and reset
  input wire pclk,
  input wire presetn,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // System status
  input wire usb_enum_done,
  // Dedicated inputs
  input wire input_line_a,
  input wire input_line_b,
  // Dual direction port, enable low while driving
  input wire dual_direction_port_in,
  output reg dual_direction_port_out,
  output reg dual_direction_port_oe_n,
  // Dedicated outputs
  output reg output_line_a,
  output reg output_line_b,
  output reg output_drive_en,
  // Line terminations, bit 0 dual port, 1 line a, 2 line b
  output reg [NLINES-1:0] term_en,
  // Status
  output reg ports_enabled,
  output reg irq
);

  // Full width first, then cut on purpose to the tick counter width
  localparam [31:0] TICK_SPAN = TICK_CYCLES - 1;
  localparam [`TICK_W-1:0] TICK_LAST = TICK_SPAN[`TICK_W-1:0];
  localparam NIRQ = 2 * NLINES;

  // Sticky flag update where a new set always wins over a clear
  function [NIRQ-1:0] sticky;
    input [NIRQ-1:0] cur;
    input [NIRQ-1:0] set;
    input [NIRQ-1:0] clr;
    begin
      sticky = (cur & ~clr) | set;
    end
  endfunction

  // Address decode for the error answer; the read mux decodes paddr on its own
  function is_mapped;
    input [7:0] a;
    begin
      case (a)
        `REG_CTRL, `REG_LEVEL, `REG_RISE, `REG_FALL,
        `REG_DEB0, `REG_DEB1, `REG_DEB2,
        `REG_IRQ_STAT, `REG_IRQ_EN, `REG_IRQ_CLR: is_mapped = 1'b1;
        default: is_mapped = 1'b0;
      endcase
    end
  endfunction

  reg [2:0] enum_sync;
  reg [`TICK_W-1:0] tick_cnt;
  reg tick;
  reg [`CTRL_W-1:0] ctrl;
  reg [NLINES*DW-1:0] deb_time;
  reg [NLINES-1:0] level_q;
  reg log_armed;
  reg [NLINES-1:0] rise_seen_flag;
  reg [NLINES-1:0] fall_seen_flag;
  reg [NIRQ-1:0] irq_stat;
  reg [NIRQ-1:0] irq_en;
  reg [31:0] rd_mux;
  wire [NLINES-1:0] raw_lines;
  wire [NLINES-1:0] level;
  wire [NLINES-1:0] rise;
  wire [NLINES-1:0] fall;
  wire [NLINES-1:0] rise_clr;
  wire [NLINES-1:0] fall_clr;
  wire [NIRQ-1:0] irq_clr;
  wire setup;
  wire access;
  wire wr;
  wire rd;
  wire dir_out;

  assign dir_out = ctrl[`CTRL_DIR];
  assign raw_lines = {input_line_b, input_line_a, dual_direction_port_in};

  // ----------------------------------------------------------------------
  // Port enable after enumeration
  // ----------------------------------------------------------------------
  // Once enabled the ports stay on; a later drop of the flag is ignored
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      enum_sync <= 3'h0;
      ports_enabled <= 1'b0;
    end else begin
      enum_sync <= {enum_sync[1:0], usb_enum_done};
      if (enum_sync[2] && enum_sync[1]) begin
        ports_enabled <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Microsecond time base
  // ----------------------------------------------------------------------
  // Free running, one tick in every TICK_CYCLES; all filters share it
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt <= {`TICK_W{1'b0}};
      tick <= 1'b0;
    end else if (tick_cnt == TICK_LAST) begin
      tick_cnt <= {`TICK_W{1'b0}};
      tick <= 1'b1;
    end else begin
      tick_cnt <= tick_cnt + {{(`TICK_W-1){1'b0}}, 1'b1};
      tick <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Filters, one per line
  // ----------------------------------------------------------------------
  // Own interval per line, so a slow switch and a fast encoder can coexist
  genvar g;
  generate
    for (g = 0; g < NLINES; g = g + 1) begin : line
      debounce_filter #(
        .W(DW)
      ) filt (
        .pclk(pclk),
        .presetn(presetn),
        .tick(tick),
        .interval(deb_time[g*DW +: DW]),
        .raw_pin(raw_lines[g]),
        .level(level[g])
      );
    end
  endgenerate

  // ----------------------------------------------------------------------
  // Edge detection on filtered levels
  // ----------------------------------------------------------------------
  // Edges while ports are off are not logged, lines are disconnected then.
  // Logging is armed one cycle after the ports come on: a line idling high
  // settles through its filter in the same cycle as the enable, and that
  // settling step out of reset is not a real edge.
  assign rise = level & ~level_q & {NLINES{log_armed}};
  assign fall = ~level & level_q & {NLINES{log_armed}};

  // Previous filtered levels
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      level_q <= {NLINES{1'b0}};
    end else begin
      level_q <= level;
    end
  end

  // Event logging arm, trails the sticky port enable by one cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      log_armed <= 1'b0;
    end else begin
      log_armed <= ports_enabled;
    end
  end

  // ----------------------------------------------------------------------
  // APB handshake
  // ----------------------------------------------------------------------
  // One wait-free access cycle; effects happen at the access edge only.
  // Read data is captured at the setup edge, so read-clear acts on exactly
  // the bits that software sees; back to back transfers need no idle cycle.
  assign setup = psel && !penable;
  assign access = psel && penable && pready;
  assign wr = access && pwrite;
  assign rd = access && !pwrite;

  always @* begin
    rd_mux = 32'h0;
    case (paddr)
      `REG_CTRL: rd_mux[`CTRL_W-1:0] = ctrl;
      `REG_LEVEL: rd_mux[`LEVEL_ON_BIT:0] = {ports_enabled, level};
      `REG_RISE: rd_mux[NLINES-1:0] = rise_seen_flag;
      `REG_FALL: rd_mux[NLINES-1:0] = fall_seen_flag;
      `REG_DEB0: rd_mux[DW-1:0] = deb_time[0 +: DW];
      `REG_DEB1: rd_mux[DW-1:0] = deb_time[DW +: DW];
      `REG_DEB2: rd_mux[DW-1:0] = deb_time[2*DW +: DW];
      `REG_IRQ_STAT: rd_mux[NIRQ-1:0] = irq_stat;
      `REG_IRQ_EN: rd_mux[NIRQ-1:0] = irq_en;
      default: rd_mux = 32'h0;
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= 32'h0;
      pslverr <= 1'b0;
    end else begin
      pready <= setup;
      pslverr <= setup && !is_mapped(paddr);
      if (setup && !pwrite) begin
        prdata <= rd_mux;
      end else if (!psel) begin
        prdata <= 32'h0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------------
  // Writes to read-only or unmapped offsets fall to the default and change
  // nothing; only unmapped ones get the error answer, from the handshake logic
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= `CTRL_RESET;
      deb_time <= {NLINES{`DEB_RESET}};
      irq_en <= {NIRQ{1'b0}};
    end else if (wr) begin
      case (paddr)
        `REG_CTRL: ctrl <= pwdata[`CTRL_W-1:0];
        `REG_DEB0: deb_time[0 +: DW] <= pwdata[DW-1:0];
        `REG_DEB1: deb_time[DW +: DW] <= pwdata[DW-1:0];
        `REG_DEB2: deb_time[2*DW +: DW] <= pwdata[DW-1:0];
        `REG_IRQ_EN: irq_en <= pwdata[NIRQ-1:0];
        default: ctrl <= ctrl;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Edge flags, cleared by reading
  // ----------------------------------------------------------------------
  // Only bits that were captured into the read data are cleared, so an
  // edge landing between setup and access edges is kept for the next read
  assign rise_clr = (rd && paddr == `REG_RISE) ? prdata[NLINES-1:0] : {NLINES{1'b0}};
  assign fall_clr = (rd && paddr == `REG_FALL) ? prdata[NLINES-1:0] : {NLINES{1'b0}};
  assign irq_clr = (wr && paddr == `REG_IRQ_CLR) ? pwdata[NIRQ-1:0] : {NIRQ{1'b0}};

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rise_seen_flag <= {NLINES{1'b0}};
      fall_seen_flag <= {NLINES{1'b0}};
    end else begin
      // Set beats clear, repeats merely keep the flag high
      rise_seen_flag <= (rise_seen_flag & ~rise_clr) | rise;
      fall_seen_flag <= (fall_seen_flag & ~fall_clr) | fall;
    end
  end

  // ----------------------------------------------------------------------
  // Interrupt status and output
  // ----------------------------------------------------------------------
  // Registered output, so irq trails the status by one cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat <= {NIRQ{1'b0}};
      irq <= 1'b0;
    end else begin
      irq_stat <= sticky(irq_stat, {fall, rise}, irq_clr);
      irq <= |(irq_stat & irq_en);
    end
  end

  // ----------------------------------------------------------------------
  // Pin drive and terminations
  // ----------------------------------------------------------------------
  // Everything held off until enumeration to keep bus current low
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dual_direction_port_out <= 1'b0;
      dual_direction_port_oe_n <= 1'b1;
      output_line_a <= 1'b0;
      output_line_b <= 1'b0;
      output_drive_en <= 1'b0;
      term_en <= {NLINES{1'b0}};
    end else begin
      dual_direction_port_oe_n <= !(ports_enabled && dir_out);
      dual_direction_port_out <= ports_enabled && dir_out && ctrl[`CTRL_OUT_LSB];
      output_line_a <= ports_enabled && ctrl[`CTRL_OUT_LSB+1];
      output_line_b <= ports_enabled && ctrl[`CTRL_OUT_LSB+2];
      output_drive_en <= ports_enabled;
      // Dual port termination only while it listens
      term_en <= {NLINES{ports_enabled}} &
                 ctrl[`CTRL_TERM_LSB +: NLINES] &
                 {{(NLINES-1){1'b1}}, !dir_out};
    end
  end

endmodule

/* verilog/io_defines.vh */
// Constants for the camera I/O input block: register map, fields, timing.
// Assumes a 100 MHz APB clock and byte addresses on paddr[7:0].
// Operation
// - Two input ports, two output ports and one port of selectable direction.
// - Ports stay disabled after power-on until USB enumeration completes.
// - Each input has a software switchable internal line termination.
// - Debounce passes a new level only after it stays stable the interval.
// - Accepted transitions are delayed by the interval from true stability.
// - Interval is 0 to 65535 us in 1 us steps; zero bypasses filtering.
// - Each input line has its own filter and its own interval.
// - Rising and falling filtered edges set separate readable flags per input.
// - Reading an edge flag returns it and clears it in the same access.
// - Repeated edges between reads just keep the flag set, no count kept.
// - Dual port powers up as input, termination off, until set to output.
`ifndef IO_DEFINES_VH
`define IO_DEFINES_VH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define REG_CTRL 8'h00
`define REG_LEVEL 8'h04
`define REG_RISE 8'h08
`define REG_FALL 8'h0c
`define REG_DEB0 8'h10
`define REG_DEB1 8'h14
`define REG_DEB2 8'h18
`define REG_IRQ_STAT 8'h1c
`define REG_IRQ_EN 8'h20
`define REG_IRQ_CLR 8'h24

// ----------------------------------------------------------------------
// Control fields and reset values
// ----------------------------------------------------------------------
`define CTRL_DIR 0
`define CTRL_TERM_LSB 1
`define CTRL_OUT_LSB 4
`define CTRL_W 7
`define CTRL_RESET 7'h00
`define LEVEL_ON_BIT 3
`define IRQ_FALL_LSB 3
`define DEB_W 16
`define DEB_RESET 16'h0000

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define CLK_FREQ_MHZ 100
`define TICK_PERIOD_US 1
`define TICK_CYCLES (`CLK_FREQ_MHZ * `TICK_PERIOD_US)
`define TICK_W 7

`endif

/* verilog/debounce_filter.v */
// One input line: three-stage synchroniser and stability filter.
// Assumes a one-cycle tick every microsecond from the parent.
`timescale 1ns/1ps
`include "io_defines.vh"

module debounce_filter #(
  parameter W = `DEB_W
) (
  // Clock and reset
  input wire pclk,
  input wire presetn,
  // Time base and setting
  input wire tick,
  input wire [W-1:0] interval,
  // Line
  input wire raw_pin,
  output reg level
);

  reg [2:0] sync;
  reg cand;
  reg [W-1:0] cnt;
  wire agree;
  wire sampled;

  // Change counts only once stages two and three agree
  assign agree = (sync[1] == sync[2]);
  assign sampled = sync[2];

  // ----------------------------------------------------------------------
  // Synchroniser
  // ----------------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync <= 3'h0;
    end else begin
      sync <= {sync[1:0], raw_pin};
    end
  end

  // ----------------------------------------------------------------------
  // Stability filter
  // ----------------------------------------------------------------------
  // Tick phase is free running, so one extra tick is waited to make the
  // stable time at least the interval; the price is up to 1 us more delay.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      level <= 1'b0;
      cand <= 1'b0;
      cnt <= {W{1'b0}};
    end else if (interval == {W{1'b0}}) begin
      if (agree) begin
        level <= sampled;
      end
      cand <= level;
      cnt <= {W{1'b0}};
    end else if (!agree) begin
      cnt <= cnt; // Unsettled sample, hold
    end else if (sampled == level) begin
      cand <= level;
      cnt <= {W{1'b0}};
    end else if (sampled != cand) begin
      cand <= sampled;
      cnt <= {W{1'b0}};
    end else if (tick) begin
      if (cnt == interval) begin
        level <= cand;
        cnt <= {W{1'b0}};
      end else begin
        cnt <= cnt + {{(W-1){1'b0}}, 1'b1};
      end
    end
  end

endmodule

/* bench/io_pin_source.sv */
// Pin source model: the outside equipment on the three input pins.
// Assumes a running pclk for timing; single-ended push-pull levels.
`timescale 1ns/1ps

module io_pin_source (
  // Clock
  input wire logic pclk,
  // Raw pin levels
  output logic [2:0] pins
);
  initial pins = 3'b000;
  // Bouncy edge: n pulses of gap cycles, then settle on v
  task automatic drive(input int ln, input logic v, input int n, input int gap);
    for (int k = 0; k < n; k++) begin
      @(posedge pclk) pins[ln] <= v;
      repeat (gap) @(posedge pclk);
      pins[ln] <= ~v;
      repeat (gap) @(posedge pclk);
    end
    @(posedge pclk) pins[ln] <= v;
  endtask
endmodule

/* bench/io_input_debounce_events_monitor.sv */
// Port monitor for the I/O block: bus answer, port enable, dual pin.
// Assumes it is bound into every instance; one clock domain.
`timescale 1ns/1ps

module io_events_monitor #(
  parameter NLINES = 3
) (
  // Clock, reset and bus
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Status and pins
  input wire logic usb_enum_done,
  input wire logic dual_direction_port_oe_n,
  input wire logic output_drive_en,
  input wire logic [NLINES-1:0] term_en,
  input wire logic ports_enabled
);
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // Setup phase of a transfer and the enumeration event
  sequence s_setup; psel && !penable; endsequence
  sequence s_enum; $rose(usb_enum_done) && !ports_enabled; endsequence
  property p_access; s_setup |=> pready; endproperty
  a_access: assert property (p_access) else $error("no bus answer");
  property p_unmapped; s_setup ##0 (paddr > 8'h27) |=> pslverr && prdata == 32'h0; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped not refused");
  property p_off; !ports_enabled |-> !output_drive_en && term_en == '0; endproperty
  a_off: assert property (p_off) else $error("ports driven while off");
  property p_sticky; ports_enabled |=> ports_enabled; endproperty
  a_sticky: assert property (p_sticky) else $error("ports dropped");
  // Sync stages keep ports off for two samples, then enable soon after
  property p_enum; s_enum |-> !ports_enabled [*2] ##[1:4] ports_enabled; endproperty
  a_enum: assert property (p_enum) else $error("enable lag wrong");
  property p_follow; $rose(ports_enabled) |=> output_drive_en; endproperty
  a_follow: assert property (p_follow) else $error("outputs not enabled");
  property p_dual_term; !dual_direction_port_oe_n |-> !term_en[0]; endproperty
  a_dual_term: assert property (p_dual_term) else $error("term on while driving");
  property p_reset_in; $rose(presetn) |-> dual_direction_port_oe_n; endproperty
  a_reset_in: assert property (p_reset_in) else $error("dual not input");
endmodule

bind io_input_debounce_events io_events_monitor #(.NLINES(NLINES)) io_events_monitor_i (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .paddr(paddr),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .usb_enum_done(usb_enum_done),
  .dual_direction_port_oe_n(dual_direction_port_oe_n), .output_drive_en(output_drive_en),
  .term_en(term_en), .ports_enabled(ports_enabled));

/* bench/io_input_debounce_events_test.sv */
// Self-checking bench for the I/O block: APB tasks and a pin source.
// Assumes the pin model and the port monitor are compiled first.
`timescale 1ns/1ps
`include "io_defines.vh"

module io_input_debounce_events_test;
  localparam int TK = 4;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic usb_enum_done = 1'b0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, err, dout, oe_n, out_a, out_b, drv, pen, irq;
  logic [2:0] pins, term_en;
  logic [6:0] c;
  wire logic dual_w;
  int errors = 0;
  int tests_run = 0;
  int seed = 32'h5831;
  int i;
  // ----------------------------------------
  // Clock, pin wire, instances
  // ----------------------------------------
  initial begin
    forever #5 pclk = ~pclk;
  end
  // Dual pin carries the block's value while it drives
  assign dual_w = oe_n ? pins[0] : dout;
  io_pin_source io_pin_source_i (.pclk(pclk), .pins(pins));
  io_input_debounce_events #(.TICK_CYCLES(TK)) io_input_debounce_events_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .usb_enum_done(usb_enum_done), .input_line_a(pins[1]), .input_line_b(pins[2]),
    .dual_direction_port_in(dual_w), .dual_direction_port_out(dout),
    .dual_direction_port_oe_n(oe_n), .output_line_a(out_a), .output_line_b(out_b),
    .output_drive_en(drv), .term_en(term_en), .ports_enabled(pen), .irq(irq));
  // ----------------------------------------
  // Tasks and expectations
  // ----------------------------------------
  // One transfer; request held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1 && ++n < 40);
    if (pready !== 1'b1) begin
      errors++;
      $display("wrong value pready expected 1 seen %b", pready);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(nm, exp, rd);
  endtask
  // Pins from control: dual term off while driving, dual value 0 unless driving
  function automatic logic [6:0] pins_exp(input logic [6:0] v);
    return {v[3:2], v[1] & ~v[0], v[6:5], v[4] & v[0], ~v[0]};
  endfunction
  task automatic final_report;
    $display("checks %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // Watchdog: the sequence needs well under 2000 cycles
  initial begin
    #50000;
    errors++;
    final_report();
  end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    // Differential sources, camera last on the line: every termination on
    apb(1'b1, `REG_CTRL, 32'h7e);
    chk("off pins", 32'h1, {drv, term_en, out_b, out_a, dout, oe_n});
    rchk("ctrl", `REG_CTRL, 32'h7e);
    usb_enum_done <= 1'b1;
    i = 0;
    while (pen !== 1'b1 && i < 20) begin
      @(posedge pclk);
      i++;
    end
    chk("enum lag", 32'h1, {31'h0, i >= 3 && i <= 7});
    repeat (2) @(posedge pclk);
    chk("on pins", {1'b1, pins_exp(7'h7e)}, {drv, term_en, out_b, out_a, dout, oe_n});
    // Random control words, first one a driven dual pin asking for term
    for (i = 0; i < 10; i++) begin
      c = (i == 0) ? 7'h13 : 7'($random(seed));
      apb(1'b1, `REG_CTRL, {25'h0, c});
      repeat (2) @(posedge pclk);
      chk("pins", {25'h0, pins_exp(c)}, {term_en, out_b, out_a, dout, oe_n});
    end
    $display("test port control done");
    apb(1'b1, `REG_DEB0, 32'h1ffff);
    rchk("deb max", `REG_DEB0, 32'hffff);
    apb(1'b1, `REG_DEB0, 32'h0);
    apb(1'b1, `REG_DEB1, 32'h3);
    apb(1'b1, `REG_DEB2, 32'h0);
    // Single-ended sources, so every termination goes off
    apb(1'b1, `REG_CTRL, 32'h0);
    repeat (8) @(posedge pclk);
    apb(1'b0, `REG_RISE, 32'h0);
    apb(1'b0, `REG_FALL, 32'h0);
    apb(1'b1, `REG_IRQ_CLR, 32'h3f);
    // Clean edge on dual, bounces shorter than the interval on a, unfiltered bounces on b
    fork
      io_pin_source_i.drive(0, 1'b1, 0, 0);
      io_pin_source_i.drive(1, 1'b1, 3, 2);
      io_pin_source_i.drive(2, 1'b1, 3, 2);
    join
    repeat (6) @(posedge pclk);
    rchk("level early", `REG_LEVEL, 32'hd);
    rchk("rise early", `REG_RISE, 32'h5);
    repeat (20) @(posedge pclk);
    rchk("level late", `REG_LEVEL, 32'hf);
    rchk("rise late", `REG_RISE, 32'h2);
    rchk("rise clear", `REG_RISE, 32'h0);
    rchk("fall", `REG_FALL, 32'h4);
    rchk("fall clear", `REG_FALL, 32'h0);
    $display("test debounce done");
    rchk("irq stat", `REG_IRQ_STAT, 32'h27);
    apb(1'b1, `REG_IRQ_EN, 32'h20);
    repeat (3) @(posedge pclk);
    chk("irq on", 32'h1, {31'h0, irq});
    apb(1'b1, `REG_IRQ_EN, 32'h18);
    repeat (3) @(posedge pclk);
    chk("irq masked", 32'h0, {31'h0, irq});
    apb(1'b1, `REG_IRQ_EN, 32'h3f);
    apb(1'b1, `REG_IRQ_CLR, 32'h3f);
    repeat (3) @(posedge pclk);
    chk("irq clear", 32'h0, {31'h0, irq});
    rchk("stat clear", `REG_IRQ_STAT, 32'h0);
    apb(1'b0, 8'h40, 32'h0);
    chk("unmapped", 32'h1, {31'h0, err});
    chk("unmapped data", 32'h0, rd);
    $display("test irq and bus done");
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    chk("second reset", 32'h1, {30'h0, pen, oe_n});
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    // Pins idle high here; coming out of reset must not log an edge
    repeat (8) @(posedge pclk);
    rchk("reset rise", `REG_RISE, 32'h0);
    rchk("reset fall", `REG_FALL, 32'h0);
    $display("test second reset done");
    final_report();
  end
endmodule
